// >>> hdl/auth_regs_params.svh
// Offsets, field positions, reset values and timing counts for the auth register bank.
// Assumes a 250 MHz core clock; included by the package and the design modules.
`ifndef AUTH_REGS_PARAMS_SVH
`define AUTH_REGS_PARAMS_SVH

// --------------------------------------------------------------
// Address map: bank in [5:4], location in [3:0]
// --------------------------------------------------------------
`define ADDR_CONFIG          6'h00
`define ADDR_TRIM            6'h01
`define ADDR_SET_ONE_LO      6'h02
`define ADDR_SET_ONE_HI      6'h05
`define ADDR_SET_TWO_LO      6'h06
`define ADDR_SET_TWO_HI      6'h09
`define ADDR_SET_THREE_LO    6'h0A
`define ADDR_SET_THREE_HI    6'h0D
`define ADDR_MASTER_CONTROL  6'h10
`define ADDR_DEVICE_STATUS   6'h11
`define ADDR_SECRET_SELECT   6'h20

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define CFG_ADDR_HI          7
`define CFG_ADDR_LO          6
`define CFG_IRQ_BIT          3
`define CFG_SLEEP_BIT        2
`define CFG_LOCK_HI          1
`define CFG_LOCK_LO          0
`define CTL_ROM_IRQ_BIT      7
`define CTL_GLOBAL_IRQ_BIT   6
`define CTL_SLEEP_BIT        1
`define CTL_SOFT_RESET_TRIGGER_BIT         0
`define STS_ROM_PEND_BIT     7
`define STS_BUS_ERR_BIT      6
`define STS_ACC_ERR_BIT      5

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define COEF_SEL_RESET       2'h1
`define SEED_SEL_RESET       2'h2
`define SEL_INVALID          2'h0

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CLK_PERIOD_NS        4
`define SLEEP_IDLE_S         1
`define SLEEP_IDLE_CYCLES    ((`SLEEP_IDLE_S * 1000000000) / `CLK_PERIOD_NS)
`define SOFT_RESET_TRIGGER_SEQ_CYCLES      4
`define BREAK_PULSE_NS       40
`define BREAK_PULSE_CYCLES   (`BREAK_PULSE_NS / `CLK_PERIOD_NS)

`endif

// >>> hdl/auth_regs_pkg.sv
// Types shared by the auth register bank.
// Assumes auth_regs_params.svh is on the include path.
`include "auth_regs_params.svh"

package auth_regs_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [5:0] reg_addr_t;

  // Soft reset sequencer states
  typedef enum logic [1:0] {
    RST_IDLE,
    RST_RUN,
    RST_BREAK
  } soft_reset_trigger_state_e;

endpackage : auth_regs_pkg

// >>> hdl/sleep_timer.sv
// Bus inactivity timer that requests sleep when auto-sleep is on.
// Assumes activity and clear are synchronous to clk.
`timescale 1ns/1ns
`include "auth_regs_params.svh"

module sleep_timer #(
  parameter int unsigned IDLE_CYCLES = `SLEEP_IDLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic activity,
  input  wire logic clear,
  output logic      expired
);

  logic [27:0] count_q;
  logic [27:0] count_d;
  logic        expired_q;
  logic        expired_d;

  // --------------------------------------------------------------
  // Idle counter
  // --------------------------------------------------------------
  // Any bus activity or a soft reset restarts the idle window
  always_comb begin
    count_d   = count_q;
    expired_d = 1'b0;
    if (!enable || activity || clear) begin
      count_d = 28'h0000000;
    end else if (count_q == 28'(IDLE_CYCLES - 1)) begin
      expired_d = 1'b1;
      count_d   = 28'h0000000;
    end else begin
      count_d = count_q + 28'h0000001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q   <= 28'h0000000;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q;

endmodule : sleep_timer

// >>> hdl/auth_regs.sv
// Control, status and secret-selection register bank of the auth hash device.
// Assumes a bus front end on clk decodes frames into access strobes and events,
// and an OTP array that presents the config byte and the twelve secret bytes.
//
// How it works
// - Lock bit 1 blocks sets one, two
// - Lock bit 0 blocks set three
// - ROM irq enable reads one until locked
// - ROM pending flag raises interrupt when enabled
// - Global enable gates bus/access error interrupts
// - Auto-sleep after one idle second
// - Soft reset reloads config, then break pulse
// - Access during OTP write sets pending flag
// - Bus error events set bus error flag
// - Locked OTP write, trim access outside test mode set flag
// - Status read clears flags, writes ignored
// - Status shows device address setting
// - Status shows secret lockout bits
// - Address setting decodes chip-select field
// - Coefficient select field, reset one
// - Seed select field, reset two
`timescale 1ns/1ns
`include "auth_regs_params.svh"

module auth_regs
  import auth_regs_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = `SLEEP_IDLE_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire auth_regs_pkg::reg_addr_t acc_addr,
  input  wire logic                    acc_read,
  input  wire logic                    acc_write,
  input  wire auth_regs_pkg::byte_t    acc_wdata,
  input  wire logic                    frame_cs,
  input  wire logic                    bus_active,
  input  wire logic                    sleep_opcode,
  input  wire logic                    rom_busy,
  input  wire logic                    test_mode,
  input  wire logic                    ev_bad_pulse,
  input  wire logic                    ev_early_bus,
  input  wire logic                    ev_bad_count,
  input  wire logic                    ev_bad_auth,
  input  wire logic                    challenge_done,
  input  wire auth_regs_pkg::byte_t    otp_config,
  input  wire logic [95:0]             otp_secrets,
  output auth_regs_pkg::byte_t         rd_data,
  output logic                         rd_valid,
  output logic                         frame_selected,
  output logic                         otp_write_en,
  output logic [31:0]                  coef_secret,
  output logic [31:0]                  seed_secret,
  output logic                         irq,
  output logic                         break_pulse,
  output logic                         sleep_req
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic        ctl_irq_q, ctl_irq_d;
  logic        ctl_sleep_q, ctl_sleep_d;
  logic        rom_irq_en_q, rom_irq_en_d;
  logic [1:0]  addr_set_q, addr_set_d;
  logic [1:0]  lock_q, lock_d;
  logic [2:0]  flags_q, flags_d;
  logic [1:0]  coef_sel_q, coef_sel_d;
  logic [1:0]  seed_sel_q, seed_sel_d;
  byte_t       rd_data_q, rd_data_d;
  logic        rd_valid_q, rd_valid_d;
  logic        sel_q, sel_d;
  logic        wr_en_q, wr_en_d;
  logic [31:0] coef_q, coef_d;
  logic [31:0] seed_q, seed_d;
  logic        irq_q, irq_d;
  logic        brk_q, brk_d;
  logic        load_q, load_d;
  soft_reset_trigger_state_e rst_state_q, rst_state_d;
  logic [3:0]  rst_cnt_q, rst_cnt_d;
  logic        sleep_hit;

  // --------------------------------------------------------------
  // Access qualification
  // --------------------------------------------------------------
  logic        in_set12, in_set3, locked_access, any_access;
  logic        set12_blocked, set3_blocked, trim_blocked, rom_area;
  byte_t       sec_byte;
  logic        soft_reset_trigger_req;

  assign any_access    = (acc_read || acc_write) && sel_q;
  assign in_set12      = acc_addr >= `ADDR_SET_ONE_LO && acc_addr <= `ADDR_SET_TWO_HI;
  assign in_set3       = acc_addr >= `ADDR_SET_THREE_LO && acc_addr <= `ADDR_SET_THREE_HI;
  assign rom_area      = acc_addr[5:4] == 2'h0;
  assign set12_blocked = in_set12 && lock_q[`CFG_LOCK_HI];
  assign set3_blocked  = in_set3 && lock_q[`CFG_LOCK_LO];
  assign locked_access = set12_blocked || set3_blocked;
  assign trim_blocked  = acc_addr == `ADDR_TRIM && !test_mode;
  assign soft_reset_trigger_req      = acc_write && sel_q && acc_addr == `ADDR_MASTER_CONTROL
                         && acc_wdata[`CTL_SOFT_RESET_TRIGGER_BIT];
  assign sec_byte      = otp_secrets[8 * (acc_addr[3:0] - 4'h2) +: 8];

  // Pick one of three 32-bit sets; code zero yields all zeros
  function automatic logic [31:0] pick_set(input logic [1:0] code, input logic [95:0] s);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (code)
      2'h1: r = s[31:0];
      2'h2: r = s[63:32];
      2'h3: r = s[95:64];
      2'h0: r = 32'h00000000;
    endcase
    return r;
  endfunction : pick_set

  // --------------------------------------------------------------
  // Soft reset sequencer
  // --------------------------------------------------------------
  // Reload waits a few cycles so the OTP config settles before the break
  always_comb begin
    rst_state_d = rst_state_q;
    rst_cnt_d   = rst_cnt_q;
    brk_d       = 1'b0;
    load_d      = 1'b0;
    unique case (rst_state_q)
      RST_IDLE: begin
        if (soft_reset_trigger_req) begin
          rst_state_d = RST_RUN;
          rst_cnt_d   = 4'(`SOFT_RESET_TRIGGER_SEQ_CYCLES - 1);
        end
      end
      RST_RUN: begin
        if (rst_cnt_q == 4'h0) begin
          load_d      = 1'b1;
          rst_state_d = RST_BREAK;
          rst_cnt_d   = 4'(`BREAK_PULSE_CYCLES - 1);
        end else begin
          rst_cnt_d = rst_cnt_q - 4'h1;
        end
      end
      RST_BREAK: begin
        brk_d = 1'b1;
        if (rst_cnt_q == 4'h0) begin
          rst_state_d = RST_IDLE;
        end else begin
          rst_cnt_d = rst_cnt_q - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_state_q <= RST_RUN;
      rst_cnt_q   <= 4'h0;
      brk_q       <= 1'b0;
      load_q      <= 1'b0;
    end else begin
      rst_state_q <= rst_state_d;
      rst_cnt_q   <= rst_cnt_d;
      brk_q       <= brk_d;
      load_q      <= load_d;
    end
  end

  // --------------------------------------------------------------
  // Registers, flags, read path
  // --------------------------------------------------------------
  // Config is caught by a clocked load after reset, never by the reset itself
  always_comb begin
    ctl_irq_d    = ctl_irq_q;
    ctl_sleep_d  = ctl_sleep_q;
    rom_irq_en_d = rom_irq_en_q;
    addr_set_d   = addr_set_q;
    lock_d       = lock_q;
    flags_d      = flags_q;
    coef_sel_d   = coef_sel_q;
    seed_sel_d   = seed_sel_q;
    rd_data_d    = 8'h00;
    rd_valid_d   = 1'b0;
    if (load_q) begin
      ctl_irq_d    = otp_config[`CFG_IRQ_BIT];
      ctl_sleep_d  = otp_config[`CFG_SLEEP_BIT];
      addr_set_d   = otp_config[`CFG_ADDR_HI:`CFG_ADDR_LO];
      lock_d       = otp_config[`CFG_LOCK_HI:`CFG_LOCK_LO];
      rom_irq_en_d = otp_config[`CFG_LOCK_HI:`CFG_LOCK_LO] == 2'h0;
      flags_d      = 3'h0;
      coef_sel_d   = `COEF_SEL_RESET;
      seed_sel_d   = `SEED_SEL_RESET;
    end else begin
      // Read clears first so a same-cycle event still lands
      if (acc_read && sel_q && acc_addr == `ADDR_DEVICE_STATUS) begin
        flags_d = 3'h0;
      end
      if (acc_write && sel_q) begin
        unique case (acc_addr)
          `ADDR_MASTER_CONTROL: begin
            ctl_irq_d   = acc_wdata[`CTL_GLOBAL_IRQ_BIT];
            ctl_sleep_d = acc_wdata[`CTL_SLEEP_BIT];
          end
          `ADDR_SECRET_SELECT: begin
            coef_sel_d = acc_wdata[3:2];
            seed_sel_d = acc_wdata[1:0];
          end
          default: ;
        endcase
      end
      if (any_access && rom_busy) begin
        flags_d[2] = 1'b1;
      end
      if (ev_bad_pulse || ev_early_bus || ev_bad_count || ev_bad_auth
          || (acc_read && sel_q && locked_access)
          || (challenge_done && (coef_sel_q == `SEL_INVALID
                                 || seed_sel_q == `SEL_INVALID))) begin
        flags_d[1] = 1'b1;
      end
      if ((acc_write && sel_q && rom_area && lock_q != 2'h0)
          || (any_access && acc_addr == `ADDR_TRIM && trim_blocked)) begin
        flags_d[0] = 1'b1;
      end
      if (acc_read && sel_q) begin
        rd_valid_d = 1'b1;
        if (acc_addr == `ADDR_CONFIG) begin
          rd_data_d = otp_config;
        end else if ((in_set12 || in_set3) && !locked_access) begin
          rd_data_d = sec_byte;
        end else if (acc_addr == `ADDR_MASTER_CONTROL) begin
          rd_data_d = {rom_irq_en_q, ctl_irq_q, 4'h0, ctl_sleep_q, 1'b0};
        end else if (acc_addr == `ADDR_DEVICE_STATUS) begin
          rd_data_d = {flags_q, 1'b0, addr_set_q, lock_q};
        end else if (acc_addr == `ADDR_SECRET_SELECT) begin
          rd_data_d = {4'h0, coef_sel_q, seed_sel_q};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_irq_q    <= 1'b0;
      ctl_sleep_q  <= 1'b0;
      rom_irq_en_q <= 1'b0;
      addr_set_q   <= 2'h0;
      lock_q       <= 2'h0;
      flags_q      <= 3'h0;
      coef_sel_q   <= `COEF_SEL_RESET;
      seed_sel_q   <= `SEED_SEL_RESET;
      rd_data_q    <= 8'h00;
      rd_valid_q   <= 1'b0;
    end else begin
      ctl_irq_q    <= ctl_irq_d;
      ctl_sleep_q  <= ctl_sleep_d;
      rom_irq_en_q <= rom_irq_en_d;
      addr_set_q   <= addr_set_d;
      lock_q       <= lock_d;
      flags_q      <= flags_d;
      coef_sel_q   <= coef_sel_d;
      seed_sel_q   <= seed_sel_d;
      rd_data_q    <= rd_data_d;
      rd_valid_q   <= rd_valid_d;
    end
  end

  // --------------------------------------------------------------
  // Decode, write gate, hash feed, interrupt
  // --------------------------------------------------------------
  // Interrupt fires on a rising flag, not while it merely stands
  always_comb begin
    unique case (addr_set_q)
      2'h0:    sel_d = !frame_cs;
      2'h3:    sel_d = frame_cs;
      default: sel_d = 1'b1;
    endcase
    wr_en_d = acc_write && sel_q && (in_set12 || in_set3 || acc_addr == `ADDR_CONFIG)
              && lock_q == 2'h0 && !rom_busy;
    coef_d  = pick_set(coef_sel_q, otp_secrets);
    seed_d  = pick_set(seed_sel_q, otp_secrets);
    irq_d   = (rom_irq_en_q && flags_d[2] && !flags_q[2])
              || (ctl_irq_q && ((flags_d[1] && !flags_q[1])
                                || (flags_d[0] && !flags_q[0])));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q   <= 1'b0;
      wr_en_q <= 1'b0;
      coef_q  <= 32'h00000000;
      seed_q  <= 32'h00000000;
      irq_q   <= 1'b0;
    end else begin
      sel_q   <= sel_d;
      wr_en_q <= wr_en_d;
      coef_q  <= coef_d;
      seed_q  <= seed_d;
      irq_q   <= irq_d;
    end
  end

  // Idle timer; cleared by the soft reset reload, while the sleep opcode requests sleep directly
  sleep_timer #(
    .IDLE_CYCLES (SLEEP_CYCLES)
  ) u_sleep_timer (
    .clk      (clk),
    .resetn   (resetn),
    .enable   (ctl_sleep_q),
    .activity (bus_active),
    .clear    (load_q),
    .expired  (sleep_hit)
  );

  logic sleep_q, sleep_d;
  assign sleep_d = sleep_hit || sleep_opcode;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  assign rd_data        = rd_data_q;
  assign rd_valid       = rd_valid_q;
  assign frame_selected = sel_q;
  assign otp_write_en   = wr_en_q;
  assign coef_secret    = coef_q;
  assign seed_secret    = seed_q;
  assign irq            = irq_q;
  assign break_pulse    = brk_q;
  assign sleep_req      = sleep_q;

endmodule : auth_regs

// >>> tb/otp_array_model.sv
// OTP array model: config byte, twelve secret bytes, write busy time.
// Assumes the bench sets the programmed config byte directly.
`timescale 1ns/1ns

module otp_array_model #(
  parameter logic [95:0] SECRETS = 96'h0,
  parameter int unsigned BUSY    = 20
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  cfg_in,
  input  wire logic        write_en,
  output logic [7:0]       otp_config,
  output logic [95:0]      otp_secrets,
  output logic             rom_busy
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Contents fixed; programming only costs time here
  assign otp_config  = cfg_in;
  assign otp_secrets = SECRETS;

  // Busy window after each write, so late accesses collide
  always_comb begin
    cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
    if (write_en) begin
      cnt_d = 8'(BUSY);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign rom_busy = (cnt_q != 8'h00);
endmodule : otp_array_model

// >>> tb/auth_regs_monitor.sv
// Checker for the auth register bank, bound to auth_regs.
// Assumes only bank ports; config is captured as the break pulse starts.
`timescale 1ns/1ns
`include "auth_regs_params.svh"

module auth_regs_monitor
  import auth_regs_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = 100
) (
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire auth_regs_pkg::reg_addr_t  acc_addr,
  input wire logic                      acc_read,
  input wire logic                      acc_write,
  input wire auth_regs_pkg::byte_t      acc_wdata,
  input wire logic                      frame_cs,
  input wire logic                      sleep_opcode,
  input wire logic                      rom_busy,
  input wire logic                      challenge_done,
  input wire auth_regs_pkg::byte_t      otp_config,
  input wire auth_regs_pkg::byte_t      rd_data,
  input wire logic                      rd_valid,
  input wire logic                      frame_selected,
  input wire logic                      otp_write_en,
  input wire logic                      irq,
  input wire logic                      break_pulse,
  input wire logic                      sleep_req
);
  logic [3:0] brk_q, brk_d;
  logic [3:0] cfg_q, cfg_d;
  logic       rdy_q, rdy_d;
  logic       soft_reset_trigger, stat_rd, quiet;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Helpers: break length, config seen at reload, settled flag
  assign soft_reset_trigger    = acc_write && frame_selected && acc_addr == `ADDR_MASTER_CONTROL && acc_wdata[0];
  assign stat_rd = acc_read && frame_selected && acc_addr == `ADDR_DEVICE_STATUS;
  assign quiet   = !challenge_done && !rom_busy && !irq;
  always_comb begin
    brk_d = break_pulse ? brk_q + 4'h1 : 4'h0;
    cfg_d = (break_pulse && brk_q == 4'h0) ? {otp_config[7:6], otp_config[1:0]} : cfg_q;
    rdy_d = soft_reset_trigger ? 1'b0 : (!break_pulse && brk_q != 4'h0) ? 1'b1 : rdy_q;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brk_q <= 4'h0;
      cfg_q <= 4'h0;
      rdy_q <= 1'b0;
    end else begin
      brk_q <= brk_d;
      cfg_q <= cfg_d;
      rdy_q <= rdy_d;
    end
  end

  // ------
  // Assertions
  // ------
  a_status_clear: assert property (stat_rd && quiet ##1 stat_rd && quiet |=> rd_data[7:5] == 3'h0)
    else $error("status flags survived a read");
  a_sel_unused: assert property (rd_valid && $past(acc_addr) == `ADDR_SECRET_SELECT |-> rd_data[7:4] == 4'h0)
    else $error("selection upper bits not zero");
  a_lock_set_one: assert property (rdy_q && rd_valid && cfg_q[1] && $past(acc_addr) inside {[6'h02:6'h09]} |-> rd_data == 8'h00)
    else $error("locked set one or two readable");
  a_lock_set_three: assert property (rdy_q && rd_valid && cfg_q[0] && $past(acc_addr) inside {[6'h0A:6'h0D]} |-> rd_data == 8'h00)
    else $error("locked set three readable");
  a_rom_irq_en: assert property (rdy_q && rd_valid && $past(acc_addr) == `ADDR_MASTER_CONTROL |-> rd_data[7] == (cfg_q[1:0] == 2'h0))
    else $error("control bit 7 wrong for lock state");
  a_status_cfg: assert property (rdy_q && rd_valid && $past(acc_addr) == `ADDR_DEVICE_STATUS |-> rd_data[4:0] == {1'b0, cfg_q})
    else $error("status config bits wrong");
  a_locked_write: assert property (rdy_q && cfg_q[1:0] != 2'h0 && acc_write && frame_selected && acc_addr <= `ADDR_SET_THREE_HI |=> !otp_write_en)
    else $error("OTP write allowed while locked");
  a_break_len: assert property (!break_pulse && brk_q != 4'h0 |-> brk_q == 4'hA)
    else $error("break pulse length wrong");
  a_soft_reset_trigger_break: assert property (rdy_q && soft_reset_trigger |-> ##[4:6] $rose(break_pulse))
    else $error("no break pulse after soft reset");
  a_sleep_cmd: assert property (rdy_q && sleep_opcode |=> sleep_req)
    else $error("sleep opcode gave no sleep request");
  a_cs_decode: assert property (rdy_q && $past(rdy_q) |-> frame_selected == ((cfg_q[3:2] == 2'h0) ? !$past(frame_cs) : (cfg_q[3:2] == 2'h3) ? $past(frame_cs) : 1'b1))
    else $error("chip-select decode wrong");

  c_irq:   cover property (irq);
  c_break: cover property ($rose(break_pulse));
  c_sleep: cover property (sleep_req);
  c_locked_rd: cover property (rdy_q && rd_valid && cfg_q[1] && $past(acc_addr) inside {[6'h02:6'h09]});
endmodule : auth_regs_monitor

bind auth_regs auth_regs_monitor #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_auth_regs_monitor (
  .clk(clk), .resetn(resetn), .acc_addr(acc_addr), .acc_read(acc_read),
  .acc_write(acc_write), .acc_wdata(acc_wdata), .frame_cs(frame_cs),
  .sleep_opcode(sleep_opcode), .rom_busy(rom_busy), .challenge_done(challenge_done),
  .otp_config(otp_config), .rd_data(rd_data), .rd_valid(rd_valid),
  .frame_selected(frame_selected), .otp_write_en(otp_write_en), .irq(irq),
  .break_pulse(break_pulse), .sleep_req(sleep_req));

// >>> tb/auth_regs_test.sv
// Self-checking bench for the auth register bank with an OTP array model.
// Assumes design and checker are compiled first; inputs change at falling edges.
`timescale 1ns/1ns
`include "auth_regs_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module auth_regs_test
  import auth_regs_pkg::*;
;
  localparam logic [95:0] S = 96'hC3D4E5F6_8899AABB_11223344;
  logic        clk = 1'b0, resetn = 1'b0, acc_read = 1'b0, acc_write = 1'b0, frame_cs = 1'b0;
  logic        sleep_op = 1'b0, chal = 1'b0, test_mode = 1'b0;
  reg_addr_t   acc_addr = 6'h00;
  byte_t       acc_wdata = 8'h00, cfg = 8'h0C, rd_data, otp_config, d;
  logic [3:0]  ev = 4'h0;
  logic        rd_valid, frame_selected, otp_write_en, irq, break_pulse, sleep_req, rom_busy, v;
  logic [31:0] coef_secret, seed_secret, w;
  logic [95:0] otp_secrets;
  int          miscompares = 0, n_tests = 0, irq_n = 0, sleep_n = 0;

  // Clock and pulse counters; pulses last one cycle
  always #2 clk = ~clk;
  always @(posedge clk) begin
    irq_n += int'(irq);
    sleep_n += int'(sleep_req);
  end

  auth_regs #(.SLEEP_CYCLES(100)) i_auth_regs (
    .clk(clk), .resetn(resetn), .acc_addr(acc_addr), .acc_read(acc_read),
    .acc_write(acc_write), .acc_wdata(acc_wdata), .frame_cs(frame_cs),
    .bus_active(acc_read | acc_write), .sleep_opcode(sleep_op), .rom_busy(rom_busy),
    .test_mode(test_mode), .ev_bad_pulse(ev[0]), .ev_early_bus(ev[1]),
    .ev_bad_count(ev[2]), .ev_bad_auth(ev[3]), .challenge_done(chal),
    .otp_config(otp_config), .otp_secrets(otp_secrets), .rd_data(rd_data),
    .rd_valid(rd_valid), .frame_selected(frame_selected), .otp_write_en(otp_write_en),
    .coef_secret(coef_secret), .seed_secret(seed_secret), .irq(irq),
    .break_pulse(break_pulse), .sleep_req(sleep_req));

  otp_array_model #(.SECRETS(S), .BUSY(20)) i_otp_array_model (
    .clk(clk), .resetn(resetn), .cfg_in(cfg), .write_en(otp_write_en),
    .otp_config(otp_config), .otp_secrets(otp_secrets), .rom_busy(rom_busy));

  // ------
  // Access tasks: strobe one cycle, data taken one cycle later
  // ------
  task automatic wr(input reg_addr_t a, input byte_t dat);
    acc_addr = a;
    acc_wdata = dat;
    acc_write = 1'b1;
    @(negedge clk);
    acc_write = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input reg_addr_t a, output byte_t dat, output logic vld);
    acc_addr = a;
    acc_read = 1'b1;
    @(negedge clk);
    dat = rd_data;
    vld = rd_valid;
    acc_read = 1'b0;
    @(negedge clk);
  endtask : rd

  task automatic chk_rd(input reg_addr_t a, input byte_t e);
    rd(a, d, v);
    `CHK("rd_valid", 1'b1, v)
    `CHK("rd_data", e, d)
  endtask : chk_rd

  task automatic pulse_ev(input int i);
    ev[i] = 1'b1;
    @(negedge clk);
    ev = 4'h0;
    repeat (3) @(negedge clk);
  endtask : pulse_ev

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog: the run needs about 480 cycles
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // ------
  // Test sequence
  // ------
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (20) @(negedge clk);
    chk_rd(`ADDR_SECRET_SELECT, 8'h06);
    chk_rd(`ADDR_MASTER_CONTROL, 8'hC2);
    chk_rd(`ADDR_DEVICE_STATUS, 8'h00);
    chk_rd(6'h30, 8'h00);
    `CHK("coef", S[31:0], coef_secret)
    `CHK("seed", S[63:32], seed_secret)
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      rd(6'(`ADDR_SET_ONE_LO + i), d, v);
      w[8*i +: 8] = d;
    end
    `CHK("set_one", S[31:0], w)
    chk_rd(`ADDR_SET_THREE_LO, S[71:64]);
    wr(`ADDR_SECRET_SELECT, 8'h0F);
    `CHK("coef", S[95:64], coef_secret)
    `CHK("seed", S[95:64], seed_secret)
    wr(`ADDR_SECRET_SELECT, 8'h00);
    chal = 1'b1;
    @(negedge clk);
    chal = 1'b0;
    @(negedge clk);
    `CHK("coef_zero", 32'h0, coef_secret)
    acc_addr = `ADDR_DEVICE_STATUS;
    acc_read = 1'b1;
    @(negedge clk);
    `CHK("status", 8'h40, rd_data)
    @(negedge clk);
    `CHK("status", 8'h00, rd_data)
    acc_read = 1'b0;
    wr(`ADDR_DEVICE_STATUS, 8'hFF);
    chk_rd(`ADDR_DEVICE_STATUS, 8'h00);
    wr(`ADDR_SECRET_SELECT, 8'h06);
    $display("test selection done");
    for (int i = 0; i < 4; i++) begin
      irq_n = 0;
      pulse_ev(i);
      `CHK("irq", 1, irq_n)
      chk_rd(`ADDR_DEVICE_STATUS, 8'h40);
    end
    wr(`ADDR_MASTER_CONTROL, 8'h02);
    irq_n = 0;
    pulse_ev(1);
    `CHK("irq_masked", 0, irq_n)
    wr(6'(`ADDR_TRIM), 8'h55);
    chk_rd(`ADDR_DEVICE_STATUS, 8'h60);
    // Trim access in test mode must leave the access error flag clear
    test_mode = 1'b1;
    wr(6'(`ADDR_TRIM), 8'h55);
    chk_rd(`ADDR_DEVICE_STATUS, 8'h00);
    test_mode = 1'b0;
    wr(`ADDR_SET_THREE_LO, 8'h5A);
    wr(`ADDR_SECRET_SELECT, 8'h06);
    repeat (3) @(negedge clk);
    `CHK("irq_rom", 1, irq_n)
    repeat (25) @(negedge clk);
    chk_rd(`ADDR_DEVICE_STATUS, 8'h80);
    $display("test flags done");
    wr(`ADDR_MASTER_CONTROL, 8'h00);
    sleep_n = 0;
    repeat (150) @(negedge clk);
    `CHK("no_auto_sleep", 0, sleep_n)
    sleep_op = 1'b1;
    @(negedge clk);
    sleep_op = 1'b0;
    @(negedge clk);
    `CHK("sleep_cmd", 1, sleep_n)
    wr(`ADDR_MASTER_CONTROL, 8'h02);
    chk_rd(`ADDR_MASTER_CONTROL, 8'h82);
    sleep_n = 0;
    repeat (150) @(negedge clk);
    `CHK("auto_sleep", 1, sleep_n)
    $display("test sleep done");
    cfg = 8'hC3;
    wr(`ADDR_MASTER_CONTROL, 8'h01);
    repeat (20) @(negedge clk);
    frame_cs = 1'b1;
    @(negedge clk);
    chk_rd(`ADDR_MASTER_CONTROL, 8'h00);
    chk_rd(`ADDR_SET_ONE_LO, 8'h00);
    chk_rd(`ADDR_SET_THREE_HI, 8'h00);
    wr(`ADDR_SET_TWO_LO, 8'hA5);
    chk_rd(`ADDR_DEVICE_STATUS, 8'h6F);
    frame_cs = 1'b0;
    @(negedge clk);
    rd(`ADDR_DEVICE_STATUS, d, v);
    `CHK("unselected", 1'b0, v)
    $display("test lockout done");
    end_sim();
  end
endmodule : auth_regs_test
